// ==== design/otg_regs_pkg.sv ====
// Package with register map, field positions and timing for the OTG register bank.
package otg_regs_pkg;

    localparam logic [3:0] ADDR_IRQ_EN    = 4'h0;
    localparam logic [3:0] ADDR_STATUS    = 4'h4;
    localparam logic [3:0] ADDR_CONTROL   = 4'h8;
    localparam logic [3:0] ADDR_EVENTS    = 4'hc;

    localparam int         CLK_MHZ        = 200;
    localparam int         STABLE_TIME_US = 1000;
    localparam int         STABLE_CYCLES  = STABLE_TIME_US * CLK_MHZ;

    localparam logic [7:0] IRQ_EN_MASK    = 8'hfd;
    localparam logic [7:0] IRQ_EN_RESET   = 8'h00;
    localparam logic [7:0] CONTROL_RESET  = 8'h00;

    localparam int         BIT_CABLE      = 7;
    localparam int         BIT_MILLI      = 6;
    localparam int         BIT_STABLE     = 5;
    localparam int         BIT_ACTIVITY   = 4;
    localparam int         BIT_SESSION    = 3;
    localparam int         BIT_B_END      = 2;
    localparam int         BIT_A_VALID    = 0;

    localparam int         BIT_DP_UP      = 7;
    localparam int         BIT_DM_UP      = 6;
    localparam int         BIT_DP_DOWN    = 5;
    localparam int         BIT_DM_DOWN    = 4;
    localparam int         BIT_POWER      = 3;
    localparam int         BIT_SW_PULL    = 2;
    localparam int         BIT_CHARGE     = 1;
    localparam int         BIT_DISCHARGE  = 0;

    typedef struct packed {
        logic dplus_pullup_en;
        logic dminus_pullup_en;
        logic dplus_pulldown_en;
        logic dminus_pulldown_en;
    } pull_set_t;

endpackage

// ==== design/usb_otg_status_control_regs.sv ====
// OTG enable, status and control registers on an Avalon-MM slave.
//
// Contract
// - Bits 31 to 8 read zero, ignore writes
// - Enable bit 7 gates cable-type change interrupt
// - Enable bit 6 gates millisecond timer interrupt
// - Enable bit 5 gates line-stable interrupt
// - Enable bit 4 gates bus-activity interrupt
// - Enable bit 3 gates session-valid interrupt
// - Enable bit 2 gates session-end interrupt
// - Enable bit 0 gates VBUS-valid; bit 1 zero
// - Status bit 7 shows cable type pin
// - Status bits 6, 4, 1 read zero
// - Status bit 5: line unchanged one millisecond
// - Status bit 3: VBUS above session valid
// - Status bit 2: B-device session ended
// - Status bit 0: A-device VBUS valid
// - Control bit 7 drives D+ pull-up
// - Control bits 6..4 drive other pulls
// - Control bit 3 powers VBUS
// - Control bit 2 selects software pull control
// - Control bits 1, 0 charge/discharge VBUS
`timescale 1ns/10ps

module usb_otg_status_control_regs #(
    parameter int STABLE_COUNT = otg_regs_pkg::STABLE_CYCLES
) (
    // Clock and reset.
    input  wire  logic                    clk,
    input  wire  logic                    reset_n,
    // Avalon-MM slave.
    input  wire  logic [3:0]              address,
    input  wire  logic                    read,
    input  wire  logic                    write,
    input  wire  logic [3:0]              byteenable,
    input  wire  logic [31:0]             writedata,
    output logic       [31:0]             readdata,
    output logic                          waitrequest,
    // Cable and line indications.
    input  wire  logic                    cable_type_state,
    input  wire  logic                    session_valid_state,
    input  wire  logic                    b_session_end_state,
    input  wire  logic                    a_vbus_valid_state,
    input  wire  logic                    se0_indication,
    input  wire  logic                    j_line_indication,
    // Event pulses from the USB core.
    input  wire  logic                    milli_timer_expired,
    input  wire  logic                    bus_activity_seen,
    // Pull requests from the USB hardware.
    input  wire  otg_regs_pkg::pull_set_t hw_pulls,
    // Line drives and interrupt.
    output otg_regs_pkg::pull_set_t       line_pulls,
    output logic                          bus_power_drive,
    output logic                          bus_charge_en,
    output logic                          bus_discharge_en,
    output logic                          otg_irq
);

    if (STABLE_COUNT < 2 || STABLE_COUNT > 32'h3fffffff) begin : g_bad_count
        $error("STABLE_COUNT out of range");
    end

    typedef struct packed {
        logic [31:0]             readdata;
        logic                    waitrequest;
        logic [7:0]              irq_en;
        logic [7:0]              control;
        logic [7:0]              events;
        logic [7:0]              status;
        logic [1:0]              line_last;
        logic [31:0]             stable_cnt;
        otg_regs_pkg::pull_set_t pulls;
        logic                    irq;
        logic                    live;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [7:0] status_now;
    logic [7:0] set_ev;
    logic       access;

    always_comb begin
        st_nxt = st_r;
        access = (read || write) && st_r.waitrequest;
        status_now = 8'h00;
        status_now[otg_regs_pkg::BIT_CABLE] = cable_type_state;
        status_now[otg_regs_pkg::BIT_STABLE] = (st_r.stable_cnt == 32'(STABLE_COUNT - 1));
        status_now[otg_regs_pkg::BIT_SESSION] = session_valid_state;
        status_now[otg_regs_pkg::BIT_B_END] = b_session_end_state;
        status_now[otg_regs_pkg::BIT_A_VALID] = a_vbus_valid_state;
        st_nxt.status = status_now;

        st_nxt.line_last = {se0_indication, j_line_indication};
        if (st_nxt.line_last != st_r.line_last) begin
            st_nxt.stable_cnt = 32'h00000000;
        end else if (st_r.stable_cnt != 32'(STABLE_COUNT - 1)) begin
            st_nxt.stable_cnt = st_r.stable_cnt + 32'h00000001;
        end

        // Change and event detection.
        set_ev = 8'h00;
        set_ev[otg_regs_pkg::BIT_CABLE] = status_now[otg_regs_pkg::BIT_CABLE]
                                        ^ st_r.status[otg_regs_pkg::BIT_CABLE];
        set_ev[otg_regs_pkg::BIT_MILLI] = milli_timer_expired;
        set_ev[otg_regs_pkg::BIT_STABLE] = status_now[otg_regs_pkg::BIT_STABLE]
                                         & ~st_r.status[otg_regs_pkg::BIT_STABLE];
        set_ev[otg_regs_pkg::BIT_ACTIVITY] = bus_activity_seen;
        set_ev[otg_regs_pkg::BIT_SESSION] = status_now[otg_regs_pkg::BIT_SESSION]
                                          ^ st_r.status[otg_regs_pkg::BIT_SESSION];
        set_ev[otg_regs_pkg::BIT_B_END] = status_now[otg_regs_pkg::BIT_B_END]
                                        ^ st_r.status[otg_regs_pkg::BIT_B_END];
        set_ev[otg_regs_pkg::BIT_A_VALID] = status_now[otg_regs_pkg::BIT_A_VALID]
                                          ^ st_r.status[otg_regs_pkg::BIT_A_VALID];

        // Level changes are not flagged on the first cycle out of reset, when the
        // stored status still holds its reset value and not the pins.
        st_nxt.live = 1'b1;
        if (!st_r.live) begin
            set_ev[otg_regs_pkg::BIT_CABLE] = 1'b0;
            set_ev[otg_regs_pkg::BIT_SESSION] = 1'b0;
            set_ev[otg_regs_pkg::BIT_B_END] = 1'b0;
            set_ev[otg_regs_pkg::BIT_A_VALID] = 1'b0;
        end

        // Bus slave: one wait cycle, then the answer at the next edge.
        st_nxt.waitrequest = 1'b1;
        st_nxt.readdata = 32'h00000000;
        if (access) begin
            st_nxt.waitrequest = 1'b0;
            if (read) begin
                unique case (address)
                    otg_regs_pkg::ADDR_IRQ_EN:  st_nxt.readdata = {24'h000000, st_r.irq_en};
                    otg_regs_pkg::ADDR_STATUS:  st_nxt.readdata = {24'h000000, st_r.status};
                    otg_regs_pkg::ADDR_CONTROL: st_nxt.readdata = {24'h000000, st_r.control};
                    otg_regs_pkg::ADDR_EVENTS:  st_nxt.readdata = {24'h000000, st_r.events};
                    default:                    st_nxt.readdata = 32'h00000000;
                endcase
            end
        end

        // Events: write one to clear, a new event wins over the clear.
        st_nxt.events = st_r.events;
        if (access && write && byteenable[0] && address == otg_regs_pkg::ADDR_EVENTS) begin
            st_nxt.events = st_r.events & ~writedata[7:0];
        end
        st_nxt.events = (st_nxt.events | set_ev) & otg_regs_pkg::IRQ_EN_MASK;

        if (access && write && byteenable[0]) begin
            if (address == otg_regs_pkg::ADDR_IRQ_EN) begin
                st_nxt.irq_en = writedata[7:0] & otg_regs_pkg::IRQ_EN_MASK;
            end
            if (address == otg_regs_pkg::ADDR_CONTROL) begin
                st_nxt.control = writedata[7:0];
            end
        end

        if (st_r.control[otg_regs_pkg::BIT_SW_PULL]) begin
            st_nxt.pulls.dplus_pullup_en = st_r.control[otg_regs_pkg::BIT_DP_UP];
            st_nxt.pulls.dminus_pullup_en = st_r.control[otg_regs_pkg::BIT_DM_UP];
            st_nxt.pulls.dplus_pulldown_en = st_r.control[otg_regs_pkg::BIT_DP_DOWN];
            st_nxt.pulls.dminus_pulldown_en = st_r.control[otg_regs_pkg::BIT_DM_DOWN];
        end else begin
            st_nxt.pulls = hw_pulls;
        end

        st_nxt.irq = |(st_r.events & st_r.irq_en);

        if (!reset_n) begin
            st_nxt = '0;
            st_nxt.waitrequest = 1'b1;
            st_nxt.irq_en = otg_regs_pkg::IRQ_EN_RESET;
            st_nxt.control = otg_regs_pkg::CONTROL_RESET;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign readdata = st_r.readdata;
    assign waitrequest = st_r.waitrequest;
    assign line_pulls = st_r.pulls;
    assign bus_power_drive = st_r.control[otg_regs_pkg::BIT_POWER];
    assign bus_charge_en = st_r.control[otg_regs_pkg::BIT_CHARGE];
    assign bus_discharge_en = st_r.control[otg_regs_pkg::BIT_DISCHARGE];
    assign otg_irq = st_r.irq;

    readback_upper_a: assert property (@(posedge clk) disable iff (!reset_n)
        !st_r.waitrequest |-> st_r.readdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    cable_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(st_r.events[7]) && !$past(st_r.irq_en[7]) && $past(st_r.events) == 8'h80)
        |-> !otg_irq)
        else $error("cable interrupt not masked");

    milli_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        (st_r.events == 8'h40 && st_r.irq_en[6]) |=> otg_irq)
        else $error("timer interrupt missing");

    stable_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        (st_r.events == 8'h20 && !st_r.irq_en[5]) |=> !otg_irq)
        else $error("line stable interrupt not masked");

    activity_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        (st_r.events == 8'h10 && !st_r.irq_en[4]) |=> !otg_irq)
        else $error("activity interrupt not masked");

    session_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        (st_r.events == 8'h08 && st_r.irq_en[3]) |=> otg_irq)
        else $error("session interrupt missing");

    bend_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        (st_r.events == 8'h04 && st_r.irq_en[2]) |=> otg_irq)
        else $error("session end interrupt missing");

    en_bit1_a: assert property (@(posedge clk) disable iff (!reset_n)
        !st_r.irq_en[1] && !st_r.events[1])
        else $error("enable bit 1 set");

    status_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        st_r.status[6] == 1'b0 && st_r.status[4] == 1'b0 && st_r.status[1] == 1'b0)
        else $error("reserved status bit set");

    cable_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n) |-> st_r.status[7] == $past(cable_type_state))
        else $error("cable status wrong");

    stable_reset_a: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(reset_n) && $past({se0_indication, j_line_indication}, 3)
         != $past({se0_indication, j_line_indication}, 2)) |-> !st_r.status[5])
        else $error("stable flag despite line change");

    levels_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n) |-> {st_r.status[3], st_r.status[2], st_r.status[0]} ==
        $past({session_valid_state, b_session_end_state, a_vbus_valid_state}))
        else $error("session level status wrong");

    pull_sw_a: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(reset_n) && $past(st_r.control[2])) |->
        line_pulls == $past(st_r.control[7:4]))
        else $error("software pulls not applied");

    pull_hw_a: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(reset_n) && !$past(st_r.control[2])) |-> line_pulls == $past(hw_pulls))
        else $error("hardware pulls not applied");

    power_bits_a: assert property (@(posedge clk) disable iff (!reset_n)
        {bus_power_drive, bus_charge_en, bus_discharge_en} ==
        {st_r.control[3], st_r.control[1:0]})
        else $error("VBUS drive bits wrong");

    irq_any_a: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(reset_n) && |($past(st_r.events) & $past(st_r.irq_en))) |-> otg_irq)
        else $error("interrupt not raised");

    irq_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(reset_n) && ($past(st_r.events) & $past(st_r.irq_en)) == 8'h00)
        |-> !otg_irq)
        else $error("interrupt without enabled flag");

    cable_event_a: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(reset_n) && $past(st_r.live) && st_r.status[7] != $past(st_r.status[7]))
        |-> st_r.events[7])
        else $error("cable change not flagged");

    session_event_a: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(reset_n) && $past(st_r.live) && st_r.status[3] != $past(st_r.status[3]))
        |-> st_r.events[3])
        else $error("session change not flagged");

    bend_event_a: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(reset_n) && $past(st_r.live) && st_r.status[2] != $past(st_r.status[2]))
        |-> st_r.events[2])
        else $error("session end change not flagged");

    avalid_event_a: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(reset_n) && $past(st_r.live) && st_r.status[0] != $past(st_r.status[0]))
        |-> st_r.events[0])
        else $error("VBUS valid change not flagged");

    stable_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
        (st_r.stable_cnt == 32'(STABLE_COUNT - 1)) |=> st_r.status[5])
        else $error("stable flag missing after full count");

endmodule

// ==== verif/tb_usb_otg_status_control_regs.sv ====
// Self-checking testbench for the OTG register bank.
`timescale 1ns/10ps
module tb_usb_otg_status_control_regs;
    localparam int SC = 16;
    logic        clk = 0, reset_n = 0, read = 0, write = 0;
    logic [3:0]  address = 4'h0;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic        waitrequest, otg_irq, pwr, chg, dis;
    logic        plug_a = 0, vbus_up = 0, b_role = 0, milli = 0, actv = 0;
    logic [1:0]  line = 2'h0;
    logic        cab, sv, be, av, se0, j;
    int          failures = 0, n_tests = 0;
    int          bits[7] = '{7, 6, 5, 4, 3, 2, 0};
    otg_regs_pkg::pull_set_t hw_pulls = 4'h5, line_pulls;

    always #2.5 clk = ~clk;

    usb_otg_status_control_regs #(.STABLE_COUNT(SC)) dut (.clk(clk), .reset_n(reset_n),
        .address(address), .read(read), .write(write), .byteenable(4'hf),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .cable_type_state(cab), .session_valid_state(sv), .b_session_end_state(be),
        .a_vbus_valid_state(av), .se0_indication(se0), .j_line_indication(j),
        .milli_timer_expired(milli), .bus_activity_seen(actv), .hw_pulls(hw_pulls),
        .line_pulls(line_pulls), .bus_power_drive(pwr), .bus_charge_en(chg),
        .bus_discharge_en(dis), .otg_irq(otg_irq));

    usb_cable_model cable (.clk(clk), .plug_a(plug_a), .vbus_up(vbus_up), .b_role(b_role),
        .line(line), .cable_type_state(cab), .session_valid_state(sv),
        .b_session_end_state(be), .a_vbus_valid_state(av), .se0_indication(se0),
        .j_line_indication(j));

    task automatic check(input logic [31:0] seen, exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    // One Avalon transfer, held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        check(rd[31:8], 32'h0, "upper bits");
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic t_regs();
        bus(0, otg_regs_pkg::ADDR_IRQ_EN, 0);
        check(rd, 32'h0, "enable reset");
        bus(0, otg_regs_pkg::ADDR_CONTROL, 0);
        check(rd, 32'h0, "control reset");
        bus(1, otg_regs_pkg::ADDR_IRQ_EN, 32'hffffffff);
        bus(0, otg_regs_pkg::ADDR_IRQ_EN, 0);
        check(rd, 32'h000000fd, "enable bits");
        bus(1, otg_regs_pkg::ADDR_CONTROL, 32'hffffffff);
        bus(0, otg_regs_pkg::ADDR_CONTROL, 0);
        check(rd, 32'h000000ff, "control bits");
        check({line_pulls, pwr, chg, dis}, 7'h7f, "drives all on");
        bus(1, otg_regs_pkg::ADDR_CONTROL, 32'h00000045);
        cyc(2);
        check({line_pulls, pwr, chg, dis}, {4'h4, 3'b001}, "sw pulls");
        bus(1, otg_regs_pkg::ADDR_CONTROL, 32'h000000f8);
        cyc(2);
        check({line_pulls, pwr, chg, dis}, {hw_pulls, 3'b100}, "hw pulls");
        hw_pulls <= 4'ha;
        cyc(2);
        check(line_pulls, 4'ha, "hw pulls follow");
        $display("register test done");
    endtask

    task automatic t_status();
        logic [2:0] k;
        for (int i = 0; i < 8; i++) begin
            k = i[2:0];
            plug_a <= k[0];
            vbus_up <= k[1];
            b_role <= k[2];
            cyc(3);
            bus(1, otg_regs_pkg::ADDR_STATUS, 32'hffffffff);
            bus(0, otg_regs_pkg::ADDR_STATUS, 0);
            check(rd, {24'h0, !k[0], 2'b01, 1'b0, k[1], k[2] & !k[1], 1'b0, !k[2] & k[1]},
                  "status");
        end
        line <= 2'h1;
        // The cable model, the line compare and the status register each add one edge.
        cyc(3);
        bus(0, otg_regs_pkg::ADDR_STATUS, 0);
        check(rd & 32'h20, 32'h0, "line moved");
        cyc(SC + 4);
        bus(0, otg_regs_pkg::ADDR_STATUS, 0);
        check(rd & 32'h20, 32'h20, "line settled");
        $display("status test done");
    endtask

    // Raises the event that belongs to enable bit b, then lets it settle.
    task automatic poke(input int b);
        case (b)
            7: plug_a <= !plug_a;
            6: milli <= 1'b1;
            5: line <= line + 2'h1;
            4: actv <= 1'b1;
            2: begin
                // VBUS stays low so that only the B-device session-end level moves.
                b_role <= 1'b1;
                vbus_up <= 1'b0;
            end
            default: begin
                b_role <= 1'b0;
                vbus_up <= !vbus_up;
            end
        endcase
        @(posedge clk);
        milli <= 1'b0;
        actv <= 1'b0;
        cyc(SC + 4);
    endtask

    task automatic t_irq(input int b);
        bus(1, otg_regs_pkg::ADDR_IRQ_EN, 0);
        bus(1, otg_regs_pkg::ADDR_EVENTS, 32'hff);
        poke(b);
        check(otg_irq, 1'b0, "masked irq");
        bus(1, otg_regs_pkg::ADDR_IRQ_EN, 32'h1 << b);
        cyc(2);
        check(otg_irq, 1'b1, "enabled irq");
        bus(1, otg_regs_pkg::ADDR_EVENTS, 32'hff);
        cyc(2);
        check(otg_irq, 1'b0, "cleared irq");
        $display("interrupt test for bit %0d done", b);
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        cyc(2);
        t_regs();
        t_status();
        foreach (bits[i]) t_irq(bits[i]);
        conclude();
    end

    initial begin
        #100000;
        failures++;
        conclude();
    end
endmodule

// ==== verif/usb_cable_model.sv ====
// Behavioural USB cable model: ID pin, VBUS comparators and data-line state.
`timescale 1ns/10ps
module usb_cable_model (
    // Clock.
    input  wire logic       clk,
    // Cable conditions chosen by the bench.
    input  wire logic       plug_a,
    input  wire logic       vbus_up,
    input  wire logic       b_role,
    input  wire logic [1:0] line,
    // Levels seen by the device.
    output logic            cable_type_state,
    output logic            session_valid_state,
    output logic            b_session_end_state,
    output logic            a_vbus_valid_state,
    output logic            se0_indication,
    output logic            j_line_indication
);
    // The comparators settle one cycle after the cable changes.
    always @(posedge clk) begin
        cable_type_state    <= !plug_a;
        session_valid_state <= vbus_up;
        b_session_end_state <= b_role & !vbus_up;
        a_vbus_valid_state  <= !b_role & vbus_up;
        se0_indication      <= line[1];
        j_line_indication   <= line[0];
    end
endmodule
